// >>> tb/tb_rtc_smooth_calibration.sv
`timescale 1ns/100ps
`default_nettype none
module tb_rtc_smooth_calibration;
	import rsc_pkg::*;
	// Drive and observe
	logic        clk_i       = 1'b0;
	logic        rst_i       = 1'b1;
	logic        sys_reset_i = 1'b0;
	logic        ce          = 1'b1;
	logic        cyc         = 1'b0;
	logic        stb         = 1'b0;
	logic        we          = 1'b0;
	logic        unlock      = 1'b0;
	logic        tick        = 1'b0;
	logic [7:0]  adr         = 8'h00;
	logic [31:0] dat         = 32'h0000_0000;
	logic [31:0] rdat;
	wire logic [31:0] dat_o;
	wire logic        ack;
	wire logic        cal;
	int          n_errors    = 0;
	int          tests_run   = 0;
	// Trim settings and corrected pulses for one kernel pulse at window start
	logic [31:0] trims [8] = '{32'h0000_0000, 32'h0000_0004, 32'h0000_4003, 32'h0000_4004,
		32'h0000_2001, 32'h0000_2002, 32'h0000_8000, 32'h0000_8001};
	logic [31:0] outs  [8] = '{32'h0000_0001, 32'h0000_0000, 32'h0000_0001, 32'h0000_0000,
		32'h0000_0001, 32'h0000_0000, 32'h0000_0002, 32'h0000_0001};

	// Clock at 100 MHz
	always #5 clk_i = ~clk_i;

	rsc_rate_trim dut_u (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.sys_reset_i (sys_reset_i),
		.ce_i        (ce),
		.wb_cyc_i    (cyc),
		.wb_stb_i    (stb),
		.wb_we_i     (we),
		.wb_adr_i    (adr),
		.wb_sel_i    (4'hf),
		.wb_dat_i    (dat),
		.wb_dat_o    (dat_o),
		.wb_ack_o    (ack),
		.wr_unlock_i (unlock),
		.kclk_tick_i (tick),
		.cal_tick_o  (cal)
	);

	// Comparison of any value
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// One classic cycle; holds everything until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
		if (n >= 50) chk("bus ack", 32'h0000_0001, 32'h0000_0000);
	endtask : wb

	// Reset pulse of one edge; system reset restarts the window
	task automatic pulse_reset(input logic por);
		@(posedge clk_i);
		if (por) rst_i <= 1'b1;
		else sys_reset_i <= 1'b1;
		@(posedge clk_i);
		rst_i       <= 1'b0;
		sys_reset_i <= 1'b0;
	endtask : pulse_reset

	// One kernel pulse, then count corrected pulses; idle cycles follow it
	task automatic kpulse(output logic [31:0] cnt);
		cnt = 32'h0000_0000;
		@(posedge clk_i);
		tick <= 1'b1;
		repeat (5) begin
			@(posedge clk_i);
			tick <= 1'b0;
			if (cal === 1'b1) cnt = cnt + 32'h0000_0001;
		end
	endtask : kpulse

	// Verdict, reached from the tests and from the watchdog
	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : test_done

	// Watchdog far beyond the two hundred or so cycles the tests need
	initial begin
		#200000;
		n_errors++;
		test_done();
	end

	// Main sequence
	initial begin
		logic [31:0] got;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, RSC_TRIM_OFS, 32'h0000_0000);
		chk("trim after power on", RSC_TRIM_RESET, rdat);
		wb(1'b1, RSC_TRIM_OFS, 32'h0000_0005);
		wb(1'b0, RSC_TRIM_OFS, 32'h0000_0000);
		chk("trim locked write", 32'h0000_0000, rdat);
		unlock <= 1'b1;
		// Both window selects never set together by software
		wb(1'b1, RSC_TRIM_OFS, 32'hffff_bfff);
		wb(1'b0, RSC_TRIM_OFS, 32'h0000_0000);
		chk("trim reserved bits", 32'h0000_a1ff, rdat);
		pulse_reset(1'b0);
		wb(1'b0, RSC_TRIM_OFS, 32'h0000_0000);
		chk("trim after system reset", 32'h0000_a1ff, rdat);
		wb(1'b1, 8'h44, 32'hffff_ffff);
		wb(1'b0, 8'h44, 32'h0000_0000);
		chk("unmapped read", 32'h0000_0000, rdat);
		for (int i = 0; i < 8; i++) begin
			wb(1'b1, RSC_TRIM_OFS, trims[i]);
			pulse_reset(1'b0);
			kpulse(got);
			chk("corrected pulses", outs[i], got);
			kpulse(got);
			chk("pulse off slot", 32'h0000_0001, got);
		end
		// Clock enable low freezes the gate: no pulse out, window position kept
		ce <= 1'b0;
		kpulse(got);
		chk("pulses while frozen", 32'h0000_0000, got);
		ce <= 1'b1;
		wb(1'b0, RSC_STAT_OFS, 32'h0000_0000);
		chk("window position", 32'h0000_0002, rdat);
		pulse_reset(1'b1);
		wb(1'b0, RSC_TRIM_OFS, 32'h0000_0000);
		chk("trim after second power on", RSC_TRIM_RESET, rdat);
		test_done();
	end
endmodule : tb_rtc_smooth_calibration
`default_nettype wire

// >>> verilog/rsc_cal_if.sv
`timescale 1ns/100ps
`default_nettype none
interface rsc_cal_if;
	import rsc_pkg::*;
	logic [RSC_MASK_W-1:0] mask_count;
	logic                  sixteen_sec_window_sel;
	logic                  eight_sec_window_sel;
	logic                  pulse_insert_enable;
	logic                  tick_in;
	logic                  tick_out;
	logic [RSC_WIN_W-1:0]  win_pos;

	modport ctrl (output mask_count, sixteen_sec_window_sel, eight_sec_window_sel, pulse_insert_enable,
		tick_in, input tick_out, win_pos);
	modport gate (input mask_count, sixteen_sec_window_sel, eight_sec_window_sel, pulse_insert_enable,
		tick_in, output tick_out, win_pos);
endinterface : rsc_cal_if
`default_nettype wire

// >>> verilog/rsc_pkg.sv
// Contract
// - The rate trim register changes on a write only while write protection is released.
// - The nine-bit mask count drops that many kernel pulses in every window of 2^20 pulses.
// - With the sixteen-second select set, the window is 16 s and mask count bit 0 counts as zero; the eight-second select wins if both are set.
// - With the eight-second select set, the window is 8 s and mask count bits 1 and 0 count as zero.
// - With insertion enabled one extra kernel pulse is added every 2^11 pulses, else none.
// - Insertion and masking act together, netting 512 times insert enable minus mask count per 32 s.
// - Power-on reset clears the rate trim register, system reset leaves it unchanged.
package rsc_pkg;
	// Bus geometry
	localparam int RSC_ADDR_W = 8;
	localparam int RSC_DATA_W = 32;
	localparam int RSC_LANES  = 4;
	localparam int RSC_LANE_W = 8;

	// Register offsets (byte addresses)
	localparam logic [RSC_ADDR_W-1:0] RSC_TRIM_OFS = 8'h3c;
	localparam logic [RSC_ADDR_W-1:0] RSC_STAT_OFS = 8'h80;

	// Rate trim field layout
	localparam int RSC_MASK_LSB     = 0;
	localparam int RSC_MASK_W       = 9;
	localparam int RSC_SIXTEEN_BIT  = 13;
	localparam int RSC_EIGHT_BIT    = 14;
	localparam int RSC_INSERT_BIT   = 15;
	localparam logic [RSC_DATA_W-1:0] RSC_TRIM_RESET = 32'h0000_0000;
	localparam logic [RSC_DATA_W-1:0] RSC_TRIM_WMASK = 32'h0000_e1ff;

	// Mask count bits forced to zero by the shortened windows
	localparam logic [RSC_MASK_W-1:0] RSC_M16_CLR = 9'h001;
	localparam logic [RSC_MASK_W-1:0] RSC_M8_CLR  = 9'h003;

	// Window counter: 2^20 pulses, slots of 2^11 pulses, 2^9 slots
	localparam int RSC_WIN_W      = 20;
	localparam int RSC_SLOT_W     = 11;
	localparam int RSC_SLOT_IDX_W = 9;
	localparam logic [RSC_WIN_W-1:0] RSC_WIN32_LAST = 20'hf_ffff;
	localparam logic [RSC_WIN_W-1:0] RSC_WIN16_LAST = 20'h7_ffff;
	localparam logic [RSC_WIN_W-1:0] RSC_WIN8_LAST  = 20'h3_ffff;
endpackage : rsc_pkg

// >>> verilog/rsc_pulse_gate.sv
`timescale 1ns/100ps
`default_nettype none
module rsc_pulse_gate (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic ce_i,
	// Trim settings and kernel pulses
	rsc_cal_if.gate   cal
);
	import rsc_pkg::*;

	typedef struct packed {
		logic [RSC_WIN_W-1:0] cnt;
		logic                 pend;
		logic                 tick;
	} rsc_gate_state_type;

	rsc_gate_state_type        st_reg;
	rsc_gate_state_type        st_next;
	logic [RSC_MASK_W-1:0]     m_eff;
	logic [RSC_WIN_W-1:0]      last;
	logic [RSC_SLOT_IDX_W-1:0] rev;
	logic                      slot;
	logic                      masked;

	// Bit-reversed slot index spreads masked slots evenly over the window
	for (genvar i = 0; i < RSC_SLOT_IDX_W; i++) begin : g_rev
		assign rev[i] = st_reg.cnt[RSC_WIN_W-1-i];
	end

	// Effective mask count and window end; eight wins if both selects are set
	always_comb begin
		m_eff = cal.mask_count;
		last  = RSC_WIN32_LAST;
		if (cal.eight_sec_window_sel) begin
			m_eff = cal.mask_count & ~RSC_M8_CLR;
			last  = RSC_WIN8_LAST;
		end else if (cal.sixteen_sec_window_sel) begin
			m_eff = cal.mask_count & ~RSC_M16_CLR;
			last  = RSC_WIN16_LAST;
		end
	end

	assign slot   = (st_reg.cnt[RSC_SLOT_W-1:0] == '0);
	assign masked = slot && (rev < m_eff);

	// Next state: mask on a slot, queue insertion into the next idle cycle
	always_comb begin
		st_next      = st_reg;
		st_next.tick = 1'b0;
		if (st_reg.cnt > last) begin
			st_next.cnt = '0; // Window shortened under a running count
		end else if (cal.tick_in) begin
			st_next.cnt = (st_reg.cnt == last) ? '0 : st_reg.cnt + 1'b1;
		end
		if (cal.tick_in) begin
			st_next.tick = !masked;
			if (slot && cal.pulse_insert_enable) begin
				st_next.pend = 1'b1;
			end
		end else if (st_reg.pend) begin
			st_next.tick = 1'b1;
			st_next.pend = 1'b0;
		end
	end

	// State register; frozen while the clock enable is low
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_reg <= '0;
		end else if (ce_i) begin
			st_reg <= st_next;
		end
	end

	assign cal.tick_out = st_reg.tick;
	assign cal.win_pos  = st_reg.cnt;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_insert_slot;
		cal.tick_in && slot && cal.pulse_insert_enable && ce_i;
	endsequence
	sequence s_idle_cycle;
		!cal.tick_in && ce_i;
	endsequence

	chk_mask_drops_pulse: assert property (cal.tick_in && masked && ce_i |=> !cal.tick_out)
		else $error("masked kernel pulse was passed");
	chk_sixteen_window: assert property (cal.sixteen_sec_window_sel && !cal.eight_sec_window_sel && ce_i ##1
		cal.sixteen_sec_window_sel && !cal.eight_sec_window_sel |-> st_reg.cnt <= RSC_WIN16_LAST)
		else $error("sixteen second window overran");
	chk_eight_window: assert property (cal.eight_sec_window_sel && ce_i ##1 cal.eight_sec_window_sel
		|-> st_reg.cnt <= RSC_WIN8_LAST)
		else $error("eight second window overran");
	chk_insert_pulse: assert property (s_insert_slot ##1 s_idle_cycle |=> cal.tick_out)
		else $error("inserted pulse missing");
	chk_no_insert_off: assert property ((!st_reg.pend and s_idle_cycle) |=> !cal.tick_out)
		else $error("pulse appeared with nothing pending");
	chk_net_adjust: assert property ((s_insert_slot and masked) |=> !cal.tick_out && st_reg.pend)
		else $error("mask and insert did not both act");
	chk_mask_spread: assert property (cal.tick_in && !slot && ce_i |=> cal.tick_out)
		else $error("pulse masked outside a slot");
endmodule : rsc_pulse_gate
`default_nettype wire

// >>> verilog/rsc_rate_trim.sv
`timescale 1ns/100ps
`default_nettype none
module rsc_rate_trim (
	// Clock, resets and enable
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	input  wire logic                          sys_reset_i,
	input  wire logic                          ce_i,
	// Classic Wishbone slave
	input  wire logic                          wb_cyc_i,
	input  wire logic                          wb_stb_i,
	input  wire logic                          wb_we_i,
	input  wire logic [rsc_pkg::RSC_ADDR_W-1:0] wb_adr_i,
	input  wire logic [rsc_pkg::RSC_LANES-1:0]  wb_sel_i,
	input  wire logic [rsc_pkg::RSC_DATA_W-1:0] wb_dat_i,
	output logic      [rsc_pkg::RSC_DATA_W-1:0] wb_dat_o,
	output logic                               wb_ack_o,
	// Write protection state
	input  wire logic                          wr_unlock_i,
	// Kernel clock pulses in and to the prescaler
	input  wire logic                          kclk_tick_i,
	output logic                               cal_tick_o
);
	import rsc_pkg::*;

	typedef struct packed {
		logic                  ack;
		logic [RSC_DATA_W-1:0] dat;
		logic [RSC_DATA_W-1:0] trim;
	} rsc_regs_state_type;

	rsc_regs_state_type    st_reg;
	rsc_regs_state_type    st_next;
	logic [RSC_DATA_W-1:0] be_mask;
	logic                  take;
	logic                  gate_rst;
	rsc_cal_if             cal ();

	// Byte enables widened to a bit mask
	for (genvar i = 0; i < RSC_LANES; i++) begin : g_lane
		assign be_mask[i*RSC_LANE_W +: RSC_LANE_W] = {RSC_LANE_W{wb_sel_i[i]}};
	end

	// One request per ack; ack drops the cycle after it was given
	assign take = wb_cyc_i && wb_stb_i && !st_reg.ack;

	// Register decode; unmapped addresses ack with zero and ignore writes
	always_comb begin
		st_next     = st_reg;
		st_next.ack = take;
		if (take) begin
			st_next.dat = '0;
			if (wb_adr_i == RSC_TRIM_OFS) begin
				if (!wb_we_i) begin
					st_next.dat = st_reg.trim;
				end else if (wr_unlock_i) begin
					st_next.trim = ((st_reg.trim & ~be_mask) | (wb_dat_i & be_mask)) & RSC_TRIM_WMASK;
				end
			end else if (wb_adr_i == RSC_STAT_OFS) begin
				if (!wb_we_i) begin
					st_next.dat = RSC_DATA_W'(cal.win_pos);
				end
			end
		end
	end

	// Power-on reset clears the trim; system reset only aborts the bus side
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_reg      <= '0;
			st_reg.trim <= RSC_TRIM_RESET;
		end else if (sys_reset_i) begin
			st_reg.ack <= 1'b0;
			st_reg.dat <= '0;
		end else if (ce_i) begin
			st_reg <= st_next;
		end
	end

	assign wb_ack_o = st_reg.ack;
	assign wb_dat_o = st_reg.dat;

	// Trim fields to the pulse gate
	assign cal.mask_count             = st_reg.trim[RSC_MASK_LSB +: RSC_MASK_W];
	assign cal.sixteen_sec_window_sel = st_reg.trim[RSC_SIXTEEN_BIT];
	assign cal.eight_sec_window_sel   = st_reg.trim[RSC_EIGHT_BIT];
	assign cal.pulse_insert_enable    = st_reg.trim[RSC_INSERT_BIT];
	assign cal.tick_in                = kclk_tick_i;
	assign cal_tick_o                 = cal.tick_out;

	// Window restarts on either reset so the pattern stays in step
	assign gate_rst = rst_i || sys_reset_i;

	rsc_pulse_gate u_gate (
		.clk_i (clk_i),
		.rst_i (gate_rst),
		.ce_i  (ce_i),
		.cal   (cal.gate)
	);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_trim_write;
		take && wb_we_i && wb_adr_i == RSC_TRIM_OFS && ce_i && !sys_reset_i;
	endsequence

	chk_locked_write_ignored: assert property ((s_trim_write and !wr_unlock_i) |=> $stable(st_reg.trim))
		else $error("trim changed while protected");
	chk_unlocked_write_lands: assert property ((s_trim_write and (wr_unlock_i && wb_sel_i == '1)) |=>
		st_reg.trim == ($past(wb_dat_i) & RSC_TRIM_WMASK))
		else $error("unlocked trim write lost");
	chk_sysreset_keeps_trim: assert property (sys_reset_i |=> $stable(st_reg.trim))
		else $error("system reset altered trim");
	chk_reserved_read_zero: assert property (take && !wb_we_i && wb_adr_i == RSC_TRIM_OFS && ce_i && !sys_reset_i
		|=> wb_ack_o && (wb_dat_o & ~RSC_TRIM_WMASK) == '0)
		else $error("reserved trim bits read nonzero");
	// A frozen clock enable holds ack, so only an enabled cycle must drop it
	chk_ack_single: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	chk_ack_follows: assert property (take && ce_i && !sys_reset_i |=> wb_ack_o)
		else $error("request not acked next cycle");
endmodule : rsc_rate_trim
`default_nettype wire
